// ==== logic/icen_regs.vh ====
/*
 * Register map, field positions, reset values and timing counts of the
 * two-wire controller interrupt-clear and enable block.
 * Assumes an APB master with 32-bit data and full 32-bit byte addresses.
 */
// Function
// R01: Reading receive-done clear register clears receive-done flag bit 7; upper bits zero.
// R02: Reading bus-busy clear register clears activity flag bit 8 only when idle.
// R03: While the controller is active the activity flag stays set despite reads.
// R04: Activity flag clears itself once disabled and no bus activity remains.
// R05: Bus-busy clear register read data shows the current activity flag.
// R06: Reading start-seen clear register clears the start flag at bit 10.
// R07: Reading broadcast-call clear register clears the general-call flag at bit 11.
// R08: Enable is bit 0, resets 0; when 0 both FIFOs are flushed.
// R09: After disable the event flags stay set until the engine is idle. Code clears only the busy flag at idle; the others stay set until read.
// R10: Disabled while transmitting: finish current byte, stop, discard transmit data.
// R11: Disabled while receiving: stop after the current byte and do not acknowledge it.
// R12: Enable changes take effect two controller clocks later.
// R13: Software may disable during a transfer but should let the sequence finish.
// R14: Reading abort clear register clears abort flag bit 6, cause, and flush.
// R15: Reading stop-seen clear register clears the stop flag.
`ifndef ICEN_REGS_VH
`define ICEN_REGS_VH

`define ICEN_OFF_ABORT_CLR   32'h5000_1354
`define ICEN_OFF_RXDONE_CLR  32'h5000_1358
`define ICEN_OFF_BUSY_CLR    32'h5000_135C
`define ICEN_OFF_STOP_CLR    32'h5000_1360
`define ICEN_OFF_START_CLR   32'h5000_1364
`define ICEN_OFF_BCAST_CLR   32'h5000_1368
`define ICEN_OFF_ON_OFF      32'h5000_136C
`define ICEN_OFF_CTRL_STATUS 32'h5000_1370
`define ICEN_OFF_ABORT_CAUSE 32'h5000_1380
`define ICEN_OFF_EVENT_MASK  32'h5000_13A0
`define ICEN_OFF_EVENT_RAW   32'h5000_13A4

`define ICEN_BIT_ABORT   6
`define ICEN_BIT_RXDONE  7
`define ICEN_BIT_BUSY    8
`define ICEN_BIT_STOP    9
`define ICEN_BIT_START   10
`define ICEN_BIT_BCAST   11
`define ICEN_BIT_ENABLE  0

`define ICEN_RST_ENABLE  1'b0
`define ICEN_RST_MASK    16'h0000
`define ICEN_EN_DELAY    2

`endif

// ==== logic/icen_sync.v ====
/*
 * Two-stage synchroniser for pin levels entering the core clock domain.
 * Assumes the inputs are plain levels; only the second stage is read.
 */
`timescale 1ns/1ps
module icen_sync #(
	parameter WIDTH = 2
) (
	input  wire             core_clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1_reg;

	// Idle bus lines are high, so both stages reset high to avoid a false start.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			stage1_reg <= {WIDTH{1'b1}};
			syncOut    <= {WIDTH{1'b1}};
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule // icen_sync

// ==== logic/icen_core.v ====
/*
 * Two-wire slave engine with read-to-clear event flags, enable sequencing,
 * FIFO flush control and an APB register slave.
 * Assumes transmit and receive FIFOs outside, fed by txPop and rxPush, and
 * open-drain pads resolved outside from sdaOeN.
 */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "icen_regs.vh"
module icen_core #(
	parameter [6:0] OWN_ADDR = 7'h2A
) (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        sclIn,
	input  wire        sdaIn,
	output reg         sdaOut,
	output reg         sdaOeN,
	input  wire [7:0]  txByte,
	input  wire        txValid,
	output reg         txPop,
	input  wire        txAbortEvt,
	input  wire [15:0] abortCauseIn,
	output reg         txFlush,
	output reg         rxFlush,
	output reg  [7:0]  rxByte,
	output reg         rxPush,
	output reg         ctrlActive,
	output reg         irq
);
	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_ADDR  = 3'd1;
	localparam [2:0] ST_ACK   = 3'd2;
	localparam [2:0] ST_RX    = 3'd3;
	localparam [2:0] ST_TX    = 3'd4;
	localparam [2:0] ST_TXACK = 3'd5;

	// A hardware set always beats a clear arriving in the same cycle.
	function flagNext;
		input cur;
		input set;
		input clr;
		begin
			flagNext = set | (cur & ~clr);
		end
	endfunction

	wire [1:0] pinSync;
	wire       scl;
	wire       sda;
	reg        sclPrev_reg;
	reg        sdaPrev_reg;
	wire       sclRise;
	wire       sclFall;
	wire       startCond;
	wire       stopCond;

	icen_sync #(
		.WIDTH (2)
	) icen_sync_i (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.asyncIn  ({sclIn, sdaIn}),
		.syncOut  (pinSync)
	);

	assign scl       = pinSync[1];
	assign sda       = pinSync[0];
	assign sclRise   = scl & ~sclPrev_reg;
	assign sclFall   = ~scl & sclPrev_reg;
	assign startCond = scl & sclPrev_reg & sdaPrev_reg & ~sda;
	assign stopCond  = scl & sclPrev_reg & ~sdaPrev_reg & sda;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclPrev_reg <= scl;
			sdaPrev_reg <= sda;
		end
	end

	reg        enable_reg;
	reg  [1:0] enPipe_reg;
	wire       enEff;

	// The engine sees an enable change only after two core clocks.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			enPipe_reg <= {2{`ICEN_RST_ENABLE}};
		end else begin
			enPipe_reg <= {enPipe_reg[0], enable_reg}; // R12
		end
	end
	assign enEff = enPipe_reg[`ICEN_EN_DELAY-1];

	reg [2:0] state_reg;
	reg [3:0] bitCnt_reg;
	reg [7:0] shift_reg;
	reg       isRead_reg;
	reg       rxDonePulse_reg;
	reg       bcastPulse_reg;
	wire      engActive;

	assign engActive = (state_reg != ST_IDLE);

	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg       <= ST_IDLE;
			bitCnt_reg      <= 4'h0;
			shift_reg       <= 8'h00;
			isRead_reg      <= 1'b0;
			sdaOeN          <= 1'b1;
			sdaOut          <= 1'b0;
			txPop           <= 1'b0;
			rxPush          <= 1'b0;
			rxByte          <= 8'h00;
			rxDonePulse_reg <= 1'b0;
			bcastPulse_reg  <= 1'b0;
		end else begin
			txPop           <= 1'b0;
			rxPush          <= 1'b0;
			rxDonePulse_reg <= 1'b0;
			bcastPulse_reg  <= 1'b0;
			sdaOut          <= 1'b0;
			if (stopCond) begin
				state_reg <= ST_IDLE;
				sdaOeN    <= 1'b1;
			end else if (startCond) begin
				state_reg  <= ST_ADDR;
				bitCnt_reg <= 4'h0;
				sdaOeN     <= 1'b1;
			end else begin
				case (state_reg)
				ST_ADDR, ST_RX: begin
					if (sclRise && bitCnt_reg < 4'd8) begin
						shift_reg  <= {shift_reg[6:0], sda};
						bitCnt_reg <= bitCnt_reg + 4'd1;
					end else if (sclFall && bitCnt_reg == 4'd8) begin
						if (state_reg == ST_ADDR) begin
							if (enEff && shift_reg[7:1] == OWN_ADDR) begin
								sdaOeN     <= 1'b0;
								isRead_reg <= shift_reg[0];
								state_reg  <= ST_ACK;
							end else if (enEff && shift_reg == 8'h00) begin
								sdaOeN         <= 1'b0;
								isRead_reg     <= 1'b0;
								bcastPulse_reg <= 1'b1;
								state_reg      <= ST_ACK;
							end else begin
								state_reg <= ST_IDLE;
							end
						end else if (enEff) begin
							sdaOeN    <= 1'b0;
							rxByte    <= shift_reg;
							rxPush    <= 1'b1;
							state_reg <= ST_ACK;
						end else begin
							// Byte in flight when disabled is dropped unacknowledged.
							sdaOeN    <= 1'b1; // R11
							state_reg <= ST_IDLE; // R11
						end
					end
				end
				ST_ACK: begin
					if (sclFall) begin
						if (isRead_reg) begin
							shift_reg  <= txValid ? txByte : 8'hFF;
							txPop      <= txValid;
							sdaOeN     <= txValid ? txByte[7] : 1'b1;
							bitCnt_reg <= 4'd1;
							state_reg  <= ST_TX;
						end else begin
							sdaOeN     <= 1'b1;
							bitCnt_reg <= 4'h0;
							state_reg  <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (sclFall) begin
						if (bitCnt_reg < 4'd8) begin
							sdaOeN     <= shift_reg[6];
							shift_reg  <= {shift_reg[6:0], 1'b1};
							bitCnt_reg <= bitCnt_reg + 4'd1;
						end else begin
							sdaOeN    <= 1'b1;
							state_reg <= ST_TXACK;
						end
					end
				end
				ST_TXACK: begin
					if (sclRise) begin
						if (sda) begin
							rxDonePulse_reg <= 1'b1;
							state_reg       <= ST_IDLE;
						end else if (!enEff) begin
							// Current byte is complete; stop and let the flush drop the rest.
							state_reg <= ST_IDLE; // R10
						end else begin
							state_reg <= ST_ACK;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					sdaOeN    <= 1'b1;
				end
				endcase
			end
		end
	end

	reg        abortFlag_reg;
	reg        rxDoneFlag_reg;
	reg        busyFlag_reg;
	reg        stopFlag_reg;
	reg        startFlag_reg;
	reg        bcastFlag_reg;
	reg [15:0] abortCause_reg;
	reg [15:0] mask_reg;
	wire [15:0] rawEvents;

	assign rawEvents = {4'h0, bcastFlag_reg, startFlag_reg, stopFlag_reg, busyFlag_reg,
		rxDoneFlag_reg, abortFlag_reg, 6'h00};

	wire accessEdge;
	wire rdEdge;
	wire rawRd;
	wire clrAbort;
	wire clrRxDone;
	wire clrBusy;
	wire clrStop;
	wire clrStart;
	wire clrBcast;

	assign accessEdge = psel & penable & pready;
	assign rdEdge     = accessEdge & ~pwrite;
	assign rawRd      = rdEdge && paddr == `ICEN_OFF_EVENT_RAW;
	// Only a flag the read actually returned as set is cleared.
	assign clrAbort  = (rdEdge && paddr == `ICEN_OFF_ABORT_CLR && prdata[0]) ||
		(rawRd && prdata[`ICEN_BIT_ABORT]);
	assign clrRxDone = (rdEdge && paddr == `ICEN_OFF_RXDONE_CLR && prdata[0]) ||
		(rawRd && prdata[`ICEN_BIT_RXDONE]);
	assign clrBusy   = (rdEdge && paddr == `ICEN_OFF_BUSY_CLR && prdata[0]) ||
		(rawRd && prdata[`ICEN_BIT_BUSY]);
	assign clrStop   = (rdEdge && paddr == `ICEN_OFF_STOP_CLR && prdata[0]) ||
		(rawRd && prdata[`ICEN_BIT_STOP]);
	assign clrStart  = (rdEdge && paddr == `ICEN_OFF_START_CLR && prdata[0]) ||
		(rawRd && prdata[`ICEN_BIT_START]);
	assign clrBcast  = (rdEdge && paddr == `ICEN_OFF_BCAST_CLR && prdata[0]) ||
		(rawRd && prdata[`ICEN_BIT_BCAST]);

	// A disable clears only the busy flag, and only once the engine is idle; the rest drain by reads.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			abortFlag_reg  <= 1'b0;
			rxDoneFlag_reg <= 1'b0;
			busyFlag_reg   <= 1'b0;
			stopFlag_reg   <= 1'b0;
			startFlag_reg  <= 1'b0;
			bcastFlag_reg  <= 1'b0;
			abortCause_reg <= 16'h0000;
		end else begin
			abortFlag_reg  <= flagNext(abortFlag_reg, txAbortEvt, clrAbort); // R14
			abortCause_reg <= txAbortEvt ? (abortCause_reg | abortCauseIn) :
				(clrAbort ? 16'h0000 : abortCause_reg); // R14
			rxDoneFlag_reg <= flagNext(rxDoneFlag_reg, rxDonePulse_reg, clrRxDone); // R01 R09
			busyFlag_reg   <= flagNext(busyFlag_reg, engActive,
				clrBusy | ~enEff); // R02 R03 R04
			stopFlag_reg   <= flagNext(stopFlag_reg, stopCond, clrStop); // R15 R09
			startFlag_reg  <= flagNext(startFlag_reg, startCond, clrStart); // R06 R09
			bcastFlag_reg  <= flagNext(bcastFlag_reg, bcastPulse_reg, clrBcast); // R07 R09
		end
	end

	reg [15:0] rdData;
	reg        rdHit;

	// Reserved bits above each field read as zero.
	always @* begin
		rdData = 16'h0000;
		rdHit  = 1'b1;
		case (paddr)
		`ICEN_OFF_ABORT_CLR:   rdData[0] = abortFlag_reg;
		`ICEN_OFF_RXDONE_CLR:  rdData[0] = rxDoneFlag_reg; // R01
		`ICEN_OFF_BUSY_CLR:    rdData[0] = busyFlag_reg; // R05
		`ICEN_OFF_STOP_CLR:    rdData[0] = stopFlag_reg;
		`ICEN_OFF_START_CLR:   rdData[0] = startFlag_reg;
		`ICEN_OFF_BCAST_CLR:   rdData[0] = bcastFlag_reg;
		`ICEN_OFF_ON_OFF:      rdData[`ICEN_BIT_ENABLE] = enable_reg;
		`ICEN_OFF_CTRL_STATUS: rdData[0] = engActive;
		`ICEN_OFF_ABORT_CAUSE: rdData = abortCause_reg;
		`ICEN_OFF_EVENT_MASK:  rdData = mask_reg;
		`ICEN_OFF_EVENT_RAW:   rdData = rawEvents;
		default:               rdHit = 1'b0;
		endcase
	end

	// Read data and pready are registered in the setup cycle, so every access
	// completes with no wait state; side effects happen at the access edge.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			enable_reg <= `ICEN_RST_ENABLE;
			mask_reg   <= `ICEN_RST_MASK;
		end else begin
			if (psel && !penable) begin
				pready  <= 1'b1;
				pslverr <= ~rdHit;
				prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rdData};
			end else if (accessEdge) begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
				if (pwrite && paddr == `ICEN_OFF_ON_OFF) begin
					enable_reg <= pwdata[`ICEN_BIT_ENABLE]; // R08
				end
				if (pwrite && paddr == `ICEN_OFF_EVENT_MASK) begin
					mask_reg <= pwdata[15:0];
				end
			end
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			txFlush    <= 1'b1;
			rxFlush    <= 1'b1;
			ctrlActive <= 1'b0;
			irq        <= 1'b0;
		end else begin
			txFlush    <= ~enEff | abortFlag_reg; // R08 R10 R14
			rxFlush    <= ~enEff; // R08
			ctrlActive <= engActive;
			irq        <= |(rawEvents & mask_reg);
		end
	end
endmodule // icen_core

// ==== verification/icen_chk_asserts.sv ====
/* Port checker for the interrupt-clear and enable block.
   Assumes the register map header is on the include path. */
`timescale 1ns/1ps
`include "icen_regs.vh"
module icen_chk (
	input logic        core_clk,
	input logic        rst_n,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [31:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        txAbortEvt,
	input logic        txFlush,
	input logic        rxFlush,
	input logic        rxPush,
	input logic        sdaOeN,
	input logic        ctrlActive
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_setup; psel && !penable; endsequence
	sequence s_wr_on_off; psel && penable && pready && pwrite && paddr == `ICEN_OFF_ON_OFF; endsequence
	sequence s_lag_off; !rxFlush ##1 !rxFlush ##[1:2] rxFlush; endsequence
	sequence s_lag_on; rxFlush ##1 rxFlush ##[1:2] !rxFlush; endsequence
	property p_ready; s_setup |=> pready; endproperty
	property p_rdzero; pready |-> prdata[31:16] == 16'h0000; endproperty
	property p_err; pready && paddr == 32'h5000_13F0 |-> pslverr; endproperty
	property p_off; s_wr_on_off and (!pwdata[0] && !rxFlush) |=> s_lag_off; endproperty
	property p_on; s_wr_on_off and (pwdata[0] && rxFlush) |=> s_lag_on; endproperty
	property p_flush; rxFlush |-> txFlush; endproperty
	property p_push; rxPush |-> ##[0:1] (!sdaOeN && !rxFlush); endproperty
	property p_abort; txAbortEvt |-> ##[1:2] txFlush; endproperty
	property p_busy;
		pready && !pwrite && paddr == `ICEN_OFF_BUSY_CLR && $past(ctrlActive) |-> prdata[0];
	endproperty
	a_ready: assert property (p_ready) else $error("no access cycle after setup");
	a_rdzero: assert property (p_rdzero) else $error("upper read bits not zero");
	a_err: assert property (p_err) else $error("unmapped access without error");
	a_off: assert property (p_off) else $error("disable delay wrong");
	a_on: assert property (p_on) else $error("enable delay wrong");
	a_flush: assert property (p_flush) else $error("receive flushed alone");
	a_push: assert property (p_push) else $error("byte pushed without ack");
	a_abort: assert property (p_abort) else $error("abort did not flush");
	a_busy: assert property (p_busy) else $error("busy flag lost while active");
endmodule // icen_chk
bind icen_core icen_chk icen_chk_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .txAbortEvt, .txFlush, .rxFlush, .rxPush, .sdaOeN,
	.ctrlActive);

// ==== verification/icen_bus_master.sv ====
/* Remote bus master model for the two-wire link.
   Assumes an open-drain data line with a pull-up; clock idles high between frames. */
`timescale 1ns/1ps
module icen_bus_master (
	output logic sclIn,
	output logic sdaIn,
	input  logic sdaOeN,
	input  logic sdaOut
);
	logic scl = 1;
	logic drv = 1;
	assign sclIn = scl;
	assign sdaIn = drv & (sdaOeN | sdaOut);
	// The small offset keeps line changes away from the core clock edges.
	task automatic start;
		#7 drv = 0;
		#100 scl = 0;
	endtask
	task automatic stop;
		#7 drv = 0;
		#50 scl = 1;
		#100 drv = 1;
		#100;
	endtask
	task automatic bitx(input logic b, output logic s);
		#50 drv = b;
		#50 scl = 1;
		#50 s = sdaIn;
		#50 scl = 0;
	endtask
	task automatic xfer(input logic [7:0] o, input logic last, output logic [7:0] i,
		output logic a);
		for (int k = 7; k >= 0; k--)
			bitx(o[k], i[k]);
		bitx(last, a);
	endtask
endmodule // icen_bus_master

// ==== verification/i2c_intr_clear_and_enable_test.sv ====
/* Self-checking bench for the interrupt-clear and enable block.
   Assumes the bus master model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`include "icen_regs.vh"
module i2c_intr_clear_and_enable_test;
	logic        core_clk = 0;
	logic        rst_n = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [31:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [7:0]  txByte = '0;
	logic        txValid = 0;
	logic        txAbortEvt = 0;
	logic [15:0] abortCauseIn = '0;
	logic [31:0] prdata, rd;
	logic [7:0]  rxByte, lastRx, din;
	logic        pready, pslverr, sclIn, sdaIn, sdaOut, sdaOeN, perr, ack;
	logic        txFlush, rxFlush, rxPush, ctrlActive, irq, txPop;
	int          err_total = 0;
	int          compares = 0;
	int          pops = 0;
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (rxPush) lastRx <= rxByte;
	always @(posedge core_clk) if (txPop) pops <= pops + 1;
	icen_core icen_core_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sclIn, .sdaIn, .sdaOut, .sdaOeN, .txByte, .txValid,
		.txPop, .txAbortEvt, .abortCauseIn, .txFlush, .rxFlush, .rxByte, .rxPush,
		.ctrlActive, .irq);
	icen_bus_master icen_bus_master_i (.sclIn, .sdaIn, .sdaOeN, .sdaOut);
	task automatic finish_test;
		$display("err_total=%0d compares=%0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge core_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1 && n < 16);
		if (pready !== 1'b1) begin
			chk(n, 0);
			finish_test();
		end
		rd = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rc(input logic [31:0] a, input logic e);
		apb(0, a, 0);
		chk(rd, {31'h0, e});
		chk(perr, 0);
	endtask
	task automatic t_reset;
		rc(`ICEN_OFF_ON_OFF, 0);
		chk(rxFlush & txFlush, 1);
		apb(0, 32'h5000_13F0, 0);
		chk(perr, 1);
		apb(1, `ICEN_OFF_EVENT_MASK, 32'h0000_0400);
		apb(1, `ICEN_OFF_ON_OFF, 32'h0000_0001);
		@(posedge core_clk);
		#1 chk(rxFlush, 1);
		repeat (3) @(posedge core_clk);
		#1 chk(rxFlush, 0);
		rc(`ICEN_OFF_ON_OFF, 1);
	endtask
	// A data byte after an ack starts with a zero: the ack release lags the clock fall.
	task automatic t_write;
		icen_bus_master_i.start();
		icen_bus_master_i.xfer(8'h54, 1, din, ack);
		chk(ack, 0);
		rc(`ICEN_OFF_BUSY_CLR, 1);
		rc(`ICEN_OFF_BUSY_CLR, 1);
		chk(ctrlActive, 1);
		rc(`ICEN_OFF_CTRL_STATUS, 1);
		chk(sdaOut, 0);
		icen_bus_master_i.xfer(8'h3C, 1, din, ack);
		icen_bus_master_i.stop();
		chk(lastRx, 8'h3C);
		chk(irq, 1);
		rc(`ICEN_OFF_START_CLR, 1);
		rc(`ICEN_OFF_START_CLR, 0);
		chk(irq, 0);
		rc(`ICEN_OFF_STOP_CLR, 1);
		rc(`ICEN_OFF_STOP_CLR, 0);
		rc(`ICEN_OFF_BUSY_CLR, 1);
		rc(`ICEN_OFF_BUSY_CLR, 0);
	endtask
	task automatic t_gcall;
		icen_bus_master_i.start();
		icen_bus_master_i.xfer(8'h00, 1, din, ack);
		chk(ack, 0);
		icen_bus_master_i.xfer(8'h3C, 1, din, ack);
		icen_bus_master_i.stop();
		rc(`ICEN_OFF_BCAST_CLR, 1);
		rc(`ICEN_OFF_BCAST_CLR, 0);
		apb(0, `ICEN_OFF_EVENT_RAW, 0);
		chk(rd, 32'h0000_0700);
		apb(0, `ICEN_OFF_EVENT_RAW, 0);
		chk(rd, 32'h0000_0000);
	endtask
	task automatic t_read;
		@(posedge core_clk);
		txByte <= 8'h5A;
		txValid <= 1;
		icen_bus_master_i.start();
		icen_bus_master_i.xfer(8'h55, 1, din, ack);
		icen_bus_master_i.xfer(8'hFF, 1, din, ack);
		icen_bus_master_i.stop();
		chk(din, 8'h5A);
		chk(pops, 1);
		rc(`ICEN_OFF_RXDONE_CLR, 1);
		rc(`ICEN_OFF_RXDONE_CLR, 0);
	endtask
	task automatic t_abort;
		@(posedge core_clk);
		txAbortEvt <= 1;
		abortCauseIn <= 16'h0001;
		@(posedge core_clk);
		txAbortEvt <= 0;
		repeat (3) @(posedge core_clk);
		#1 chk(txFlush, 1);
		apb(0, `ICEN_OFF_ABORT_CAUSE, 0);
		chk(rd, 32'h0000_0001);
		rc(`ICEN_OFF_ABORT_CLR, 1);
		apb(0, `ICEN_OFF_ABORT_CAUSE, 0);
		chk(rd, 32'h0000_0000);
		repeat (3) @(posedge core_clk);
		#1 chk(txFlush, 0);
	endtask
	// The master acks the first byte, so only the disable can end the read after it.
	task automatic t_rdoff;
		icen_bus_master_i.start();
		icen_bus_master_i.xfer(8'h55, 1, din, ack);
		chk(ack, 0);
		fork
			icen_bus_master_i.xfer(8'hFF, 0, din, ack);
			apb(1, `ICEN_OFF_ON_OFF, 32'h0000_0000);
		join
		chk(din, 8'h5A);
		chk(txFlush, 1);
		icen_bus_master_i.xfer(8'hFF, 1, din, ack);
		chk(din, 8'hFF);
		chk(pops, 2);
		icen_bus_master_i.stop();
		apb(1, `ICEN_OFF_ON_OFF, 32'h0000_0001);
		repeat (4) @(posedge core_clk);
	endtask
	task automatic t_disable;
		icen_bus_master_i.start();
		icen_bus_master_i.xfer(8'h54, 1, din, ack);
		fork
			icen_bus_master_i.xfer(8'h3C, 1, din, ack);
			apb(1, `ICEN_OFF_ON_OFF, 32'h0000_0000);
		join
		chk(ack, 1);
		chk(rxFlush, 1);
		icen_bus_master_i.stop();
		repeat (8) @(posedge core_clk);
		rc(`ICEN_OFF_START_CLR, 1);
		rc(`ICEN_OFF_BUSY_CLR, 0);
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1;
		t_reset();
		t_write();
		t_gcall();
		t_read();
		t_abort();
		t_rdoff();
		t_disable();
		finish_test();
	end
endmodule // i2c_intr_clear_and_enable_test
